/* File: mit_pkg.sv */
// Constants for the modulo interval timer
package mit_pkg;
  localparam logic [7:0] MIT_CTRL_ADDR = 8'h2a;
  localparam int MIT_SEL_LO = 0;
  localparam int MIT_SEL_HI = 1;
  localparam int MIT_CLR_BIT = 2;
  localparam int MIT_RUN_BIT = 3;
  localparam logic [3:0] MIT_CTRL_RESET = 4'h0;
  localparam logic [7:0] MIT_COUNT_RESET = 8'h00;
  localparam logic [7:0] MIT_MODULO_RESET = 8'hff;
  localparam int MIT_CLK_HZ = 10_000_000;
  localparam int MIT_RATE0_HZ = 100_000;
  localparam int MIT_RATE1_HZ = 10_000;
  localparam int MIT_RATE2_HZ = 2_000;
  localparam int MIT_RATE3_HZ = 1_000;
  localparam int MIT_DIV0 = MIT_CLK_HZ / MIT_RATE0_HZ;
  localparam int MIT_DIV1 = MIT_CLK_HZ / MIT_RATE1_HZ;
  localparam int MIT_DIV2 = MIT_CLK_HZ / MIT_RATE2_HZ;
  localparam int MIT_DIV3 = MIT_CLK_HZ / MIT_RATE3_HZ;
  localparam int MIT_DIV_W = 14;
endpackage

/* File: mit_rate_gen.sv */
// Basic clock tick generator with four selectable rates
`timescale 1ns/10ps
module mit_rate_gen
  import mit_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [1:0] sel,
  output logic tick
);
  logic [MIT_DIV_W-1:0] cnt;
  logic [MIT_DIV_W-1:0] limit;
  logic at_end;
  // Free-running divider; limit follows sel directly, so a rate change applies to the period in progress
  assign limit = (sel == 2'h0) ? MIT_DIV_W'(MIT_DIV0 - 1) :
                 (sel == 2'h1) ? MIT_DIV_W'(MIT_DIV1 - 1) :
                 (sel == 2'h2) ? MIT_DIV_W'(MIT_DIV2 - 1) :
                 MIT_DIV_W'(MIT_DIV3 - 1);
  assign at_end = (cnt >= limit);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= at_end ? '0 : cnt + MIT_DIV_W'(1);
      tick <= at_end;
    end
  end
endmodule // mit_rate_gen

/* File: mit_timer.sv */
// Modulo interval timer top level
`timescale 1ns/10ps
// Summary of operation
// - An 8-bit counter counts the selected basic clock and is compared with the compare value.
// - Control bits 1:0 select 100 kHz, 10 kHz, 2 kHz or 1 kHz as the basic clock.
// - The counter advances only while control bit 3 is set and holds otherwise.
// - Writing 1 to control bit 2 clears the counter, writing 0 does nothing.
// - Control bit 2 always reads as 0.
// - An interrupt request is raised when the count reaches the compare value, unless a clear write or watchdog/stack reset comes in the same cycle.
// - A match clears the counter automatically so the interval repeats.
// - The counter value is readable through the transfer buffer.
// - The compare value is loaded from the transfer buffer on a software write.
// - Control clears on power-on and watchdog/stack reset but is kept on chip-enable reset.
// - Run changes are sampled at basic clock ticks, giving up to one tick of start or stop error.
module mit_timer
  import mit_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic WDT_STACK_RESET,
  input wire logic CE_RESET,
  input wire logic CTRL_WR,
  input wire logic [7:0] CTRL_ADDR,
  input wire logic [3:0] CTRL_WDATA,
  output logic [3:0] CTRL_RDATA,
  input wire logic MODULO_PUT,
  input wire logic COUNT_GET,
  input wire logic [7:0] TRANSFER_BUFFER_IN,
  output logic [7:0] TRANSFER_BUFFER_OUT,
  output logic IRQ
);
  logic [1:0] clock_select;
  logic run_control;
  logic [7:0] count;
  logic [7:0] modulo;
  logic tick;
  logic run_sampled;
  logic ctrl_hit;
  logic clear_req;
  logic advance;
  logic [7:0] next_count;
  logic match;

  mit_rate_gen u_rate (
    .clk(CLK),
    .rst_b(RST_B),
    .sel(clock_select),
    .tick(tick)
  );

  assign ctrl_hit = CTRL_WR && (CTRL_ADDR == MIT_CTRL_ADDR);
  assign clear_req = ctrl_hit && CTRL_WDATA[MIT_CLR_BIT];
  // Run is taken only at a tick, so start/stop land on tick boundaries
  assign advance = tick && run_sampled;
  assign next_count = count + 8'h01;
  assign match = advance && (next_count == modulo);

  // Chip-enable reset is not wired to control: contents retained
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      clock_select <= MIT_CTRL_RESET[1:0];
      run_control <= MIT_CTRL_RESET[MIT_RUN_BIT];
    end else if (WDT_STACK_RESET) begin
      clock_select <= MIT_CTRL_RESET[1:0];
      run_control <= MIT_CTRL_RESET[MIT_RUN_BIT];
    end else if (ctrl_hit) begin
      clock_select <= CTRL_WDATA[MIT_SEL_HI:MIT_SEL_LO];
      run_control <= CTRL_WDATA[MIT_RUN_BIT];
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_sampled <= 1'b0;
    end else if (WDT_STACK_RESET) begin
      run_sampled <= 1'b0;
    end else if (tick) begin
      run_sampled <= run_control;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      count <= MIT_COUNT_RESET;
    end else if (WDT_STACK_RESET || clear_req) begin
      count <= MIT_COUNT_RESET;
    end else if (match) begin
      count <= MIT_COUNT_RESET;
    end else if (advance) begin
      count <= next_count;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      modulo <= MIT_MODULO_RESET;
    end else if (WDT_STACK_RESET) begin
      modulo <= MIT_MODULO_RESET;
    end else if (MODULO_PUT) begin
      modulo <= TRANSFER_BUFFER_IN;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      IRQ <= 1'b0;
      CTRL_RDATA <= MIT_CTRL_RESET;
      TRANSFER_BUFFER_OUT <= MIT_COUNT_RESET;
    end else begin
      IRQ <= match && !clear_req && !WDT_STACK_RESET;
      CTRL_RDATA <= {run_control, 1'b0, clock_select};
      if (COUNT_GET) begin
        TRANSFER_BUFFER_OUT <= count;
      end
    end
  end

  logic unused_ce;
  assign unused_ce = CE_RESET;
endmodule // mit_timer

/* File: mit_timer_properties.sv */
// Port checks for the modulo interval timer
`timescale 1ns/10ps
module mit_timer_chk
  import mit_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic WDT_STACK_RESET,
  input wire logic CE_RESET,
  input wire logic CTRL_WR,
  input wire logic IRQ,
  input wire logic [7:0] CTRL_ADDR,
  input wire logic [3:0] CTRL_WDATA,
  input wire logic [3:0] CTRL_RDATA
);
  // A stop still lets the next tick count, so allow one slowest tick period plus pipeline
  localparam logic [13:0] stop_limit = 14'(MIT_DIV3 + 4);
  wire w = CTRL_WR && CTRL_ADDR == MIT_CTRL_ADDR && !WDT_STACK_RESET;
  wire hold = !CTRL_WR && !WDT_STACK_RESET;
  logic [13:0] stop_cnt;
  // Cycles since the readback last showed run set, saturating
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      stop_cnt <= '0;
    end else if (CTRL_RDATA[MIT_RUN_BIT]) begin
      stop_cnt <= '0;
    end else if (stop_cnt != 14'h3fff) begin
      stop_cnt <= stop_cnt + 14'h0001;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // Readback lags a write by two edges: control register first, then readback register
  AST_IRQ_PULSE: assert property (IRQ |=> !IRQ [*8]) else $error("irq width");
  AST_CLR_READ: assert property (!CTRL_RDATA[MIT_CLR_BIT]) else $error("clear bit");
  AST_WRITE: assert property (w |-> ##2 CTRL_RDATA == ($past(CTRL_WDATA, 2) & 4'hb))
    else $error("ctrl write");
  AST_BAD_ADDR: assert property (CTRL_WR && !w && !WDT_STACK_RESET |-> ##2 $stable(CTRL_RDATA))
    else $error("stray write");
  AST_CE_KEEP: assert property (CE_RESET && hold |-> ##2 $stable(CTRL_RDATA))
    else $error("ce");
  AST_WDT: assert property (WDT_STACK_RESET |-> ##2 CTRL_RDATA == MIT_CTRL_RESET)
    else $error("wdt");
  AST_CLR_WINS: assert property (w && CTRL_WDATA[MIT_CLR_BIT] |=> !IRQ) else $error("clr");
  AST_IRQ_RUN: assert property (IRQ |-> stop_cnt < stop_limit) else $error("run");
endmodule // mit_timer_chk
bind mit_timer mit_timer_chk mit_timer_chk_inst (.*);

/* File: mit_timer_bench.sv */
// Self-checking bench for the modulo interval timer
`timescale 1ns/10ps
module mit_timer_bench;
  import mit_pkg::*;
  logic CLK = 0, RST_B = 0, WDT_STACK_RESET = 0, CE_RESET = 0, CTRL_WR = 0, IRQ;
  logic MODULO_PUT = 0, COUNT_GET = 0;
  logic [7:0] CTRL_ADDR = 0, TRANSFER_BUFFER_IN = 0, TRANSFER_BUFFER_OUT;
  logic [3:0] CTRL_WDATA = 0, CTRL_RDATA;
  int errors = 0, cmp_count = 0, n, m;
  int div[4] = '{MIT_DIV0, MIT_DIV1, MIT_DIV2, MIT_DIV3};
  always #50 CLK = ~CLK;
  mit_timer mit_timer_inst (.*);
  task print_verdict;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [3:0] d);
    @(negedge CLK) CTRL_WR = 1;
    CTRL_ADDR = a;
    CTRL_WDATA = d;
    @(negedge CLK) CTRL_WR = 0;
    // Readback is registered behind the control register
    @(negedge CLK);
  endtask
  // One strobe per call: load compare, or read count and compare it
  task xfer(input bit p, input logic [7:0] v);
    @(negedge CLK) TRANSFER_BUFFER_IN = v;
    MODULO_PUT = p;
    COUNT_GET = !p;
    @(negedge CLK) MODULO_PUT = 0;
    COUNT_GET = 0;
    if (!p) chk(TRANSFER_BUFFER_OUT, v);
  endtask
  task wirq(output int c);
    c = 0;
    do begin
      @(negedge CLK) c++;
    end while (IRQ !== 1'b1 && c < 30000);
  endtask
  initial begin
    #8_000_000 errors++;
    print_verdict;
  end
  initial begin
    void'($urandom(18030));
    #300 RST_B = 1;
    chk(CTRL_RDATA, 0);
    for (int s = 0; s < 4; s++) begin
      n = $urandom;
      wr(MIT_CTRL_ADDR, {1'b0, n[0], s[1:0]});
      chk(CTRL_RDATA, s);
      wr(MIT_CTRL_ADDR ^ 8'h01, 4'hf);
      chk(CTRL_RDATA, s);
    end
    // Slow rates use a compare of 1 so the run stays short
    for (int s = 0; s < 4; s++) begin
      m = (s == 0) ? 3 + $urandom % 5 : 1;
      xfer(1, m);
      wr(MIT_CTRL_ADDR, {2'b11, s[1:0]});
      wirq(n);
      wirq(n);
      chk(n, m * div[s]);
    end
    wr(MIT_CTRL_ADDR, 4'h4);
    xfer(0, 0);
    // Compare of 8'h20 is reached while waiting, so the match clears the count before it is read
    xfer(1, 8'h20);
    wr(MIT_CTRL_ADDR, 4'hc);
    wirq(n);
    repeat (250) @(negedge CLK);
    xfer(0, 2);
    wr(MIT_CTRL_ADDR, 4'h0);
    repeat (300) @(negedge CLK);
    // The tick after a stop still counts, then the count holds
    xfer(0, 3);
    wr(MIT_CTRL_ADDR, 4'hb);
    @(negedge CLK) CE_RESET = 1;
    @(negedge CLK) CE_RESET = 0;
    chk(CTRL_RDATA, 4'hb);
    @(negedge CLK) WDT_STACK_RESET = 1;
    @(negedge CLK) WDT_STACK_RESET = 0;
    @(negedge CLK);
    chk(CTRL_RDATA, 0);
    xfer(0, 0);
    print_verdict;
  end
endmodule // mit_timer_bench
